// ---- rtl/aeil_pkg.sv ----
// Package with register map, field positions and reset values of the error interrupt block.
package aeil_pkg;
    localparam int unsigned AEIL_AW = 8;
    localparam int unsigned AEIL_DW = 32;
    localparam logic [7:0] AEIL_OFF_SUMMARY = 8'h00;
    localparam logic [7:0] AEIL_OFF_MASK = 8'h04;
    localparam logic [7:0] AEIL_OFF_BUSERR = 8'h08;
    localparam logic [7:0] AEIL_OFF_RETVEC = 8'h0C;
    localparam logic [7:0] AEIL_OFF_IVDEST = 8'h10;
    localparam int unsigned AEIL_B_PAGE_FRAME = 11;
    localparam int unsigned AEIL_B_ECC = 9;
    localparam int unsigned AEIL_B_IOADDR = 8;
    localparam int unsigned AEIL_B_INTERNAL = 7;
    localparam int unsigned AEIL_B_IOWFAIL = 6;
    localparam int unsigned AEIL_B_PWRLOW = 5;
    localparam int unsigned AEIL_B_A_DATA = 4;
    localparam int unsigned AEIL_B_A_CA = 3;
    localparam int unsigned AEIL_B_B_DATA = 2;
    localparam int unsigned AEIL_B_B_CA = 1;
    localparam int unsigned AEIL_B_IO_RD = 0;
    localparam int unsigned AEIL_B_IV_EN = 31;
    localparam int unsigned AEIL_B_TIMEOUT = 13;
    localparam logic [31:0] AEIL_SUMMARY_RST = 32'h0000_0000;
    localparam logic [31:0] AEIL_SUMMARY_MASK = 32'h0000_0BFF;
    localparam logic [31:0] AEIL_MASK_RST = 32'h0000_0000;
    localparam logic [31:0] AEIL_MASK_ERR_BITS = 32'h0000_000B;
    localparam logic [31:0] AEIL_BUSERR_RST = 32'h0000_0000;
    localparam logic [31:0] AEIL_BUSERR_MASK = 32'h0000_2000;
    localparam logic [31:0] AEIL_RETVEC_RST = 32'h0000_0000;
    localparam logic [31:0] AEIL_IVDEST_RST = 32'h0000_0000;
    localparam logic [3:0] AEIL_WRT_ERR_TYPE = 4'h1;
endpackage

// ---- rtl/aeil_top.sv ----
// Error summary, interrupt mask and interrupt issue logic of the adapter.
//
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - Buffer A data parity error sets its bit; implied vector issued if enabled.
// - Buffer A command parity error: implied vector only on write or interrupt.
// - Buffer B data parity error sets its bit; implied vector issued if enabled.
// - Buffer B command parity error: implied vector only on DMA write.
// - Error interrupt while buffer B command bit and mask bit 1 both set.
// - I/O read data parity error on read or identify sets its status bit.
// - Parity error on I/O read answers the commander with read error response.
// - Parity error on identify returns the return vector register as vector.
// - I/O read parity bit setting with mask bit 0 issues an interrupt.
// - Error interrupts come only from set error bits 0, 1 and 3 whose mask bit is set.
// - Implied vectors need mask bit 31 and a configured destination.
// - Page frame, ECC and bus address errors give implied vector on write only.
// - Internal, write failure, power low and data parity give implied vector.
// - Transaction timeout gives implied vector only on a DMA write.
module aeil_top
    import aeil_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [AEIL_AW-1:0] reg_addr,
    input wire logic [AEIL_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [AEIL_DW-1:0] reg_rdata,
    input wire logic dma_is_write,
    input wire logic dma_is_intr,
    input wire logic buf_a_data_parity_err,
    input wire logic buf_a_cmdaddr_parity_err,
    input wire logic buf_b_data_parity_err,
    input wire logic buf_b_cmdaddr_parity_err,
    input wire logic io_read_parity_err,
    input wire logic io_is_ident,
    input wire logic page_frame_number_err,
    input wire logic dma_ecc_err,
    input wire logic io_addr_err,
    input wire logic internal_err,
    input wire logic io_write_fail,
    input wire logic power_low,
    input wire logic txn_timeout,
    output logic implied_vector_interrupt,
    output logic [3:0] write_error_intr_type,
    output logic err_intr_req,
    output logic read_error_response,
    output logic ident_vector_valid,
    output logic [AEIL_DW-1:0] ident_vector,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    // Register bus decode.

    logic [31:0] summary_r;
    logic [31:0] summary_nxt;
    logic [31:0] mask_r;
    logic [31:0] mask_nxt;
    logic [31:0] buserr_r;
    logic [31:0] buserr_nxt;
    logic [31:0] retvec_r;
    logic [31:0] ivdest_r;
    logic [31:0] ev_set;
    logic [31:0] be_set;
    logic wr_summary;
    logic wr_buserr;
    logic iv_cause;
    logic iv_allowed;

    assign wr_summary = reg_wr && (reg_addr == AEIL_OFF_SUMMARY);
    assign wr_buserr = reg_wr && (reg_addr == AEIL_OFF_BUSERR);

    // The level looks at the mask as it will stand, so a mask write shows
    // on the interrupt line in the same cycle as the new mask value.
    assign mask_nxt = (reg_wr && (reg_addr == AEIL_OFF_MASK)) ? reg_wdata
                                                              : mask_r;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            mask_r <= AEIL_MASK_RST;
            retvec_r <= AEIL_RETVEC_RST;
            ivdest_r <= AEIL_IVDEST_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                AEIL_OFF_MASK: begin
                    mask_r <= reg_wdata;
                end
                AEIL_OFF_RETVEC: begin
                    retvec_r <= reg_wdata;
                end
                AEIL_OFF_IVDEST: begin
                    ivdest_r <= reg_wdata;
                end
                default: begin
                end
            endcase
        end
    end

    // Unmapped reads return zero so software probing the space sees no junk.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                AEIL_OFF_SUMMARY: reg_rdata <= summary_r;
                AEIL_OFF_MASK: reg_rdata <= mask_r;
                AEIL_OFF_BUSERR: reg_rdata <= buserr_r;
                AEIL_OFF_RETVEC: reg_rdata <= retvec_r;
                AEIL_OFF_IVDEST: reg_rdata <= ivdest_r;
                default: reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky error status.

    always_comb begin
        ev_set = '0;
        ev_set[AEIL_B_PAGE_FRAME] = page_frame_number_err;
        ev_set[AEIL_B_ECC] = dma_ecc_err;
        ev_set[AEIL_B_IOADDR] = io_addr_err;
        ev_set[AEIL_B_INTERNAL] = internal_err;
        ev_set[AEIL_B_IOWFAIL] = io_write_fail;
        ev_set[AEIL_B_PWRLOW] = power_low;
        ev_set[AEIL_B_A_DATA] = buf_a_data_parity_err;
        ev_set[AEIL_B_A_CA] = buf_a_cmdaddr_parity_err;
        ev_set[AEIL_B_B_DATA] = buf_b_data_parity_err;
        ev_set[AEIL_B_B_CA] = buf_b_cmdaddr_parity_err;
        ev_set[AEIL_B_IO_RD] = io_read_parity_err;
        be_set = '0;
        be_set[AEIL_B_TIMEOUT] = txn_timeout;
    end

    // A new event in the same cycle as a clearing write keeps its bit set.
    always_comb begin
        summary_nxt = summary_r;
        if (wr_summary) begin
            summary_nxt = summary_r & ~reg_wdata;
        end
        summary_nxt = (summary_nxt | ev_set) & AEIL_SUMMARY_MASK;
        buserr_nxt = buserr_r;
        if (wr_buserr) begin
            buserr_nxt = buserr_r & ~reg_wdata;
        end
        buserr_nxt = (buserr_nxt | be_set) & AEIL_BUSERR_MASK;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            summary_r <= AEIL_SUMMARY_RST;
            buserr_r <= AEIL_BUSERR_RST;
        end else begin
            summary_r <= summary_nxt;
            buserr_r <= buserr_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Implied vector interrupts.

    always_comb begin
        iv_cause = 1'b0;
        if (dma_is_write) begin
            iv_cause = page_frame_number_err | dma_ecc_err
                       | io_addr_err;
            iv_cause = iv_cause | buf_b_cmdaddr_parity_err;
            iv_cause = iv_cause | txn_timeout;
        end
        if (dma_is_write || dma_is_intr) begin
            iv_cause = iv_cause | buf_a_cmdaddr_parity_err;
        end
        iv_cause = iv_cause | internal_err | io_write_fail | power_low;
        iv_cause = iv_cause | buf_a_data_parity_err;
        iv_cause = iv_cause | buf_b_data_parity_err;
    end

    // Mask bit 31 is left to software; with it clear these failures go unseen.
    assign iv_allowed = mask_r[AEIL_B_IV_EN] && (ivdest_r != '0);

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            implied_vector_interrupt <= 1'b0;
            write_error_intr_type <= '0;
        end else begin
            implied_vector_interrupt <= iv_cause && iv_allowed;
            if (iv_cause && iv_allowed) begin
                write_error_intr_type <= AEIL_WRT_ERR_TYPE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Error interrupts, masked.

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            err_intr_req <= 1'b0;
            irq <= 1'b0;
        end else begin
            // A transaction goes out when bit 0, 1 or 3 newly sets while its mask bit is set.
            err_intr_req <= |(ev_set & ~summary_r & mask_r
                              & AEIL_MASK_ERR_BITS);
            // The level follows stored status so it clears with the status.
            irq <= |(summary_nxt & mask_nxt & AEIL_MASK_ERR_BITS);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // I/O read and identify answers on a read data parity error.

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            read_error_response <= 1'b0;
            ident_vector_valid <= 1'b0;
            ident_vector <= '0;
        end else begin
            read_error_response <= io_read_parity_err && !io_is_ident;
            ident_vector_valid <= io_read_parity_err && io_is_ident;
            if (io_read_parity_err && io_is_ident) begin
                ident_vector <= retvec_r;
            end
        end
    end

endmodule // aeil_top
`default_nettype wire

// ---- testbench/aeil_handler.sv ----
// Interrupt handler model on the far side of the block.
`timescale 1ns/10ps
`default_nettype none
module aeil_handler (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic implied_vector_interrupt,
    output int iv_count
);
    // Each pulse cycle is one interrupt; adjacent pulses are not merged.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            iv_count <= 0;
        end else begin
            iv_count <= iv_count + int'(implied_vector_interrupt);
        end
    end
endmodule // aeil_handler
`default_nettype wire

// ---- testbench/aeil_sva.sv ----
// Port checker of the error interrupt block.
`timescale 1ns/10ps
`default_nettype none
module aeil_sva
    import aeil_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic reg_wr,
    input wire logic dma_is_write,
    input wire logic buf_a_data_parity_err,
    input wire logic buf_a_cmdaddr_parity_err,
    input wire logic buf_b_data_parity_err,
    input wire logic buf_b_cmdaddr_parity_err,
    input wire logic io_read_parity_err,
    input wire logic io_is_ident,
    input wire logic page_frame_number_err,
    input wire logic dma_ecc_err,
    input wire logic io_addr_err,
    input wire logic internal_err,
    input wire logic io_write_fail,
    input wire logic power_low,
    input wire logic txn_timeout,
    input wire logic implied_vector_interrupt,
    input wire logic [3:0] write_error_intr_type,
    input wire logic err_intr_req,
    input wire logic read_error_response,
    input wire logic ident_vector_valid,
    input wire logic irq
);
    logic [11:0] ev;
    assign ev = {page_frame_number_err, txn_timeout, dma_ecc_err,
        io_addr_err, internal_err, io_write_fail, power_low,
        buf_a_data_parity_err, buf_a_cmdaddr_parity_err,
        buf_b_data_parity_err, buf_b_cmdaddr_parity_err, io_read_parity_err};
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////
    sequence s_b_ca_read;
        ev == 12'h002 && !dma_is_write;
    endsequence
    sequence s_io_read;
        io_read_parity_err && !io_is_ident;
    endsequence
    AST_B_CA_READ: assert property (s_b_ca_read
        |=> !implied_vector_interrupt)
        else $error("implied vector on buffer B read");
    AST_TMO_READ: assert property (ev == 12'h400 && !dma_is_write
        |=> !implied_vector_interrupt) else $error("vector on read timeout");
    AST_IV_CAUSE: assert property (implied_vector_interrupt
        |-> $past(|ev))
        else $error("implied vector without event");
    AST_IV_TYPE: assert property (implied_vector_interrupt
        |-> write_error_intr_type == AEIL_WRT_ERR_TYPE) else $error("bad type");
    AST_RD_ERR_RSP: assert property (s_io_read
        |=> read_error_response && !ident_vector_valid)
        else $error("no read error response");
    AST_IDENT: assert property (io_read_parity_err && io_is_ident
        |=> ident_vector_valid && !read_error_response) else $error("no vec");
    AST_ERR_CAUSE: assert property (err_intr_req |-> $past(|ev[3:0]))
        else $error("error interrupt without event");
    AST_ERR_IRQ: assert property (err_intr_req |-> irq)
        else $error("error interrupt without irq");
    AST_IRQ_HOLD: assert property (irq && !reg_wr |=> irq)
        else $error("irq dropped without write");
endmodule // aeil_sva
bind aeil_top aeil_sva i_aeil_sva (.*);
`default_nettype wire

// ---- testbench/aeil_bench.sv ----
// Self-checking bench of the error interrupt block.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin err_total++; \
    $display("unexpected %s exp %h got %h", n, e, s); end end
module aeil_bench
    import aeil_pkg::*;
;
    logic clk_sys = 0, rst_b = 0, reg_wr = 0, reg_rd = 0;
    logic wr = 0, intr = 0, ident = 0, iv, eir, rd_err_rsp, ivv, irq;
    logic [7:0] reg_addr = 0, adr;
    logic [31:0] reg_wdata = 0, reg_rdata, vec;
    logic [11:0] ev = 0;
    logic [3:0] iv_type;
    int err_total = 0, compares = 0, iv_count, n_iv = 0, b;
    // Row: event index, write, interrupt, implied vector expected.
    logic [6:0] rows [16] = '{7'h00, 7'h08, 7'h0D, 7'h11, 7'h18, 7'h1B,
        7'h1D, 7'h21, 7'h29, 7'h31, 7'h39, 7'h40, 7'h4D, 7'h5D, 7'h50, 7'h55};
    always #5 clk_sys = ~clk_sys;
    aeil_top i_aeil_top (.clk_sys(clk_sys), .rst_b(rst_b),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dma_is_write(wr),
        .dma_is_intr(intr), .buf_a_data_parity_err(ev[4]),
        .buf_a_cmdaddr_parity_err(ev[3]), .buf_b_data_parity_err(ev[2]),
        .buf_b_cmdaddr_parity_err(ev[1]), .io_read_parity_err(ev[0]),
        .io_is_ident(ident), .page_frame_number_err(ev[11]),
        .dma_ecc_err(ev[9]), .io_addr_err(ev[8]), .internal_err(ev[7]),
        .io_write_fail(ev[6]), .power_low(ev[5]), .txn_timeout(ev[10]),
        .implied_vector_interrupt(iv), .write_error_intr_type(iv_type),
        .err_intr_req(eir), .read_error_response(rd_err_rsp),
        .ident_vector_valid(ivv), .ident_vector(vec), .irq(irq));
    aeil_handler i_aeil_handler (.clk_sys(clk_sys), .rst_b(rst_b),
        .implied_vector_interrupt(iv), .iv_count(iv_count));
    ////////////////////////////////////////
    task automatic report_and_stop();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        {reg_wr, reg_addr, reg_wdata} <= {1'h1, a, v};
        @(posedge clk_sys);
        reg_wr <= 1'h0;
        #1;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        {reg_rd, reg_addr} <= {1'h1, a};
        @(posedge clk_sys);
        reg_rd <= 1'h0;
        #1;
        `CHK("reg_rdata", e, reg_rdata)
    endtask
    task automatic fire(input logic [11:0] e, input logic [2:0] q);
        @(posedge clk_sys);
        {ev, wr, intr} <= {e, q[2:1]};
        @(posedge clk_sys);
        {ev, wr, intr} <= 14'h0;
        #1;
        `CHK("implied_vector_interrupt", q[0], iv)
        n_iv += int'(q[0]);
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (2000) @(posedge clk_sys);
        err_total++;
        report_and_stop();
    end
    initial begin
        repeat (20) @(posedge clk_sys);
        rst_b <= 1'h1;
        rd_chk(AEIL_OFF_SUMMARY, 32'h0);
        rd_chk(AEIL_OFF_MASK, 32'h0);
        wr_reg(AEIL_OFF_IVDEST, 32'h1);
        wr_reg(AEIL_OFF_MASK, 32'h8000_0000);
        foreach (rows[k]) begin
            b = (rows[k][6:3] == 4'hA) ? 13 : int'(rows[k][6:3]);
            adr = (b == 13) ? AEIL_OFF_BUSERR : AEIL_OFF_SUMMARY;
            fire(12'h1 << rows[k][6:3], rows[k][2:0]);
            wr_reg(adr, 32'h0);
            rd_chk(adr, 32'h1 << b);
            wr_reg(adr, 32'h1 << b);
            rd_chk(adr, 32'h0);
        end
        `CHK("write_error_intr_type", AEIL_WRT_ERR_TYPE, iv_type)
        $display("table test done");
        wr_reg(AEIL_OFF_MASK, 32'h0);
        fire(12'h004, 3'h0);
        wr_reg(AEIL_OFF_MASK, 32'h8000_000B);
        wr_reg(AEIL_OFF_IVDEST, 32'h0);
        fire(12'h004, 3'h0);
        wr_reg(AEIL_OFF_RETVEC, 32'h0000_0ABC);
        ident <= 1'h1;
        fire(12'h001, 3'h0);
        `CHK("ident_vector", 32'h0000_0ABC, vec)
        `CHK("err_intr_req", 1'h1, eir)
        `CHK("ident_vector_valid", 1'h1, ivv)
        `CHK("read_error_response", 1'h0, rd_err_rsp)
        ident <= 1'h0;
        fire(12'h001, 3'h0);
        `CHK("read_error_response", 1'h1, rd_err_rsp)
        `CHK("ident_vector_valid", 1'h0, ivv)
        wr_reg(AEIL_OFF_SUMMARY, 32'h1);
        `CHK("irq", 1'h0, irq)
        wr_reg(AEIL_OFF_MASK, 32'h8000_0000);
        fire(12'h002, 3'h0);
        `CHK("err_intr_req", 1'h0, eir)
        wr_reg(AEIL_OFF_MASK, 32'h8000_0002);
        `CHK("irq", 1'h1, irq)
        @(posedge clk_sys);
        {reg_wr, reg_addr, reg_wdata, ev} <=
            {1'h1, AEIL_OFF_SUMMARY, 32'h0000_0010, 12'h010};
        @(posedge clk_sys);
        {reg_wr, ev} <= 13'h0;
        rd_chk(AEIL_OFF_SUMMARY, 32'h0000_0016);
        `CHK("iv_count", n_iv, iv_count)
        $display("hand tests done");
        rst_b <= 1'h0;
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'h1;
        #1;
        `CHK("irq", 1'h0, irq)
        rd_chk(AEIL_OFF_SUMMARY, 32'h0);
        rd_chk(AEIL_OFF_MASK, 32'h0);
        $display("reset test done");
        report_and_stop();
    end
endmodule // aeil_bench
`default_nettype wire
